//--- design/perf_count.sv
/*
  Four-channel CPU performance counter with normal and break-bounded range modes.
  Assumes event, break and host control inputs are synchronous to mclk and that
  cpu_clk_run is low while the CPU clock is halted in sleep.
*/
`default_nettype none
module perf_count (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cpu_clk_run,
  input wire perf_count_pkg::cpu_events_t cpu_ev,
  input wire perf_count_pkg::run_ctl_t run_ctl,
  input wire perf_count_pkg::src_sel_t chan_sel_in [perf_count_pkg::NUM_CHAN],
  input wire logic sel_load,
  input wire perf_count_pkg::meas_mode_t mode_in,
  input wire logic init_req,
  output logic [perf_count_pkg::NUM_CHAN-1:0][perf_count_pkg::CNT_W-1:0] count_value,
  output logic [perf_count_pkg::NUM_CHAN-1:0] overflow,
  output logic measuring,
  output logic step_allowed,
  output logic halt_request,
  output logic config_error
);
  import perf_count_pkg::*;

  typedef enum {ST_IDLE, ST_ARMED, ST_COUNT} meas_state_t;

  src_sel_t chan_sel [NUM_CHAN];
  src_sel_t next_chan_sel [NUM_CHAN];
  meas_mode_t mode;
  meas_mode_t next_mode;
  meas_state_t state;
  meas_state_t next_state;
  logic any_enabled;
  logic range_mode;
  logic start_hit;
  logic end_hit;
  logic c_acc_cyc;
  logic nc_acc_cyc;
  logic c_inst_cnt;
  logic c_data_cnt;
  logic nc_inst_cnt;
  logic nc_data_cnt;

  // increment that one selector earns this cycle
  function automatic logic [1:0] inc_for(input src_sel_t sel, input cpu_events_t ev,
                                         input logic ci, input logic cd,
                                         input logic ni, input logic nd,
                                         input logic cc, input logic nc);
    logic hit;
    hit = 1'b0;
    case (sel)
      SRC_DISABLED: hit = 1'b0;
      SRC_ELAPSED: hit = 1'b1;
      SRC_EXEC_STATE: hit = ev.exec_state;
      SRC_BRANCH: hit = ev.branch;
      SRC_INSTR: hit = ev.instr;
      SRC_DSP_INSTR: hit = ev.dsp_instr;
      SRC_MEM_CONFLICT: hit = ev.mem_conflict;
      SRC_OTHER_CONFLICT: hit = ev.other_conflict;
      SRC_EXCEPTION: hit = ev.exception;
      SRC_DTLB_MISS_CYC: hit = ev.dtlb_miss;
      SRC_ITLB_MISS_CYC: hit = ev.itlb_miss;
      SRC_INTERRUPT: hit = ev.interrupt;
      SRC_BLOCK_INSTR: hit = ev.instr & ev.block_status_bit;
      SRC_PRIV_INSTR: hit = ev.instr & ev.privileged_mode_bit;
      SRC_ICACHE_MISS: hit = ev.icache_miss;
      SRC_DCACHE_MISS: hit = ev.dcache_miss;
      SRC_IFETCH_STALL: hit = ev.ifetch_stall;
      SRC_DATA_STALL: hit = ev.data_stall;
      SRC_ICACHE_STALL: hit = ev.icache_stall;
      SRC_DCACHE_STALL: hit = ev.dcache_stall;
      SRC_CACHEABLE_STALL: hit = ev.cacheable_stall;
      SRC_XYRAM_STALL: hit = ev.xyram_stall;
      SRC_URAM_STALL: hit = ev.uram_stall;
      SRC_MEM_ACC_STALL: hit = ev.ifetch_stall | ev.data_stall;
      SRC_OTHER_ACC_CYC: hit = ev.other_acc_cyc;
      SRC_NC_ACC_CYC: hit = nc;
      SRC_NC_INST_CYC: hit = ev.inst_acc_cyc & ~ev.area_cacheable;
      SRC_NC_DATA_CYC: hit = ev.data_acc_cyc & ~ev.area_cacheable;
      SRC_C_ACC_CYC: hit = cc;
      SRC_C_INST_CYC: hit = ev.inst_acc_cyc & ev.area_cacheable;
      SRC_C_DATA_CYC: hit = ev.data_acc_cyc & ev.area_cacheable;
      SRC_OTHER_ACC_CNT: hit = ev.other_acc_start;
      SRC_NC_ACC_CNT: hit = ni | nd;
      SRC_NC_INST_CNT: hit = ni;
      SRC_NC_DATA_CNT: hit = nd;
      SRC_C_ACC_CNT: hit = ci | cd;
      SRC_C_INST_CNT: hit = ci;
      SRC_C_DATA_CNT: hit = cd;
      default: hit = 1'b0;
    endcase
    if (!hit) begin
      return INC_NONE;
    end else if (sel == SRC_BRANCH) begin
      return INC_BRANCH;
    end else begin
      return INC_ONE;
    end
  endfunction

  // area classes follow the address decode only; the TLB cache bit is not consulted
  always_comb begin
    c_acc_cyc = (cpu_ev.inst_acc_cyc | cpu_ev.data_acc_cyc) & cpu_ev.area_cacheable;
    nc_acc_cyc = (cpu_ev.inst_acc_cyc | cpu_ev.data_acc_cyc) & ~cpu_ev.area_cacheable;
    c_inst_cnt = cpu_ev.inst_acc_start & cpu_ev.area_cacheable;
    c_data_cnt = cpu_ev.data_acc_start & cpu_ev.area_cacheable;
    nc_inst_cnt = cpu_ev.inst_acc_start & ~cpu_ev.area_cacheable;
    nc_data_cnt = cpu_ev.data_acc_start & ~cpu_ev.area_cacheable;
  end

  // configuration: selectors and mode load together only in the idle state
  always_comb begin
    next_mode = mode;
    for (int i = 0; i < NUM_CHAN; i++) begin
      next_chan_sel[i] = chan_sel[i];
    end
    if (sel_load && state == ST_IDLE) begin
      next_mode = mode_in;
      for (int i = 0; i < NUM_CHAN; i++) begin
        next_chan_sel[i] = chan_sel_in[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode <= MODE_NORMAL;
      for (int i = 0; i < NUM_CHAN; i++) begin
        chan_sel[i] <= SRC_DISABLED;
      end
    end else begin
      mode <= next_mode;
      for (int i = 0; i < NUM_CHAN; i++) begin
        chan_sel[i] <= next_chan_sel[i];
      end
    end
  end

  // range decode and error check
  always_comb begin
    any_enabled = 1'b0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      any_enabled = any_enabled | (chan_sel[i] != SRC_DISABLED);
    end
    range_mode = (mode != MODE_NORMAL);
    config_error = range_mode & ~any_enabled;
    step_allowed = ~range_mode;
    halt_request = ~range_mode & (run_ctl.break1_hit | run_ctl.break2_hit
                   | run_ctl.other_break_hit);
    start_hit = (mode == MODE_RANGE_1_TO_2) ? run_ctl.break1_hit : run_ctl.break2_hit;
    end_hit = (mode == MODE_RANGE_1_TO_2) ? run_ctl.break2_hit : run_ctl.break1_hit;
  end

  // measurement window state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (run_ctl.prog_start && !range_mode) begin
          next_state = ST_COUNT;
        end else if (run_ctl.prog_start && !config_error) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (run_ctl.other_break_hit) begin
          next_state = ST_IDLE;
        end else if (start_hit) begin
          next_state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (!range_mode && halt_request) begin
          next_state = ST_IDLE;
        end else if (range_mode && (end_hit || run_ctl.other_break_hit)) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    measuring = (state == ST_COUNT);
  end

  // one counter and overflow flag per channel
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic ovf;
    logic next_ovf;
    logic [1:0] inc;
    logic [CNT_W:0] sum;

    always_comb begin
      inc = INC_NONE;
      if (measuring && cpu_clk_run) begin
        inc = inc_for(chan_sel[g], cpu_ev, c_inst_cnt, c_data_cnt, nc_inst_cnt,
                      nc_data_cnt, c_acc_cyc, nc_acc_cyc);
      end
      sum = {1'b0, (init_req ? CNT_RESET : cnt)} + {{(CNT_W - 1){1'b0}}, inc};
      next_cnt = sum[CNT_W-1:0];
      next_ovf = init_req ? 1'b0 : (ovf | sum[CNT_W]);
    end

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        cnt <= CNT_RESET;
        ovf <= 1'b0;
      end else begin
        cnt <= next_cnt;
        ovf <= next_ovf;
      end
    end

    assign count_value[g] = cnt;
    assign overflow[g] = ovf;
  end

endmodule
`default_nettype wire

//--- design/perf_count_pkg.sv
/*
  Constants, types and carriers for the four-channel CPU performance counter.
  Assumes every CPU-side event input is synchronous to mclk.
*/
// Summary of operation
// - four independent channels, each configured alone, all counting together.
// - each channel selector picks disabled or one CPU event source.
// - a branch event adds two to a branch-counting channel.
// - counting runs only while the CPU clock runs; sleep halts it.
// - every counter is 32 bits wide and fully readable.
// - a counter wrap sets a readable sticky overflow flag.
// - an initialize request clears all overflow flags and reloads each counter with zero plus that cycle's increment.
// - cacheable-area accesses count as cacheable even if TLB disables caching.
// - single-step is not allowed while a range mode is selected.
// - block and privileged instruction counts count only while that bit is one.
// - normal mode counts from program start until any break hits.
// - range modes count from start condition to end condition, either order.
// - range-bound break conditions do not halt program execution.
`default_nettype none
package perf_count_pkg;
  localparam int NUM_CHAN = 4;
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
  localparam logic [1:0] INC_NONE = 2'h0;
  localparam logic [1:0] INC_ONE = 2'h1;
  localparam logic [1:0] INC_BRANCH = 2'h2;

  typedef enum logic [5:0] {
    SRC_DISABLED, SRC_ELAPSED, SRC_EXEC_STATE, SRC_BRANCH, SRC_INSTR, SRC_DSP_INSTR,
    SRC_MEM_CONFLICT, SRC_OTHER_CONFLICT, SRC_EXCEPTION, SRC_DTLB_MISS_CYC,
    SRC_ITLB_MISS_CYC, SRC_INTERRUPT, SRC_BLOCK_INSTR, SRC_PRIV_INSTR, SRC_ICACHE_MISS,
    SRC_DCACHE_MISS, SRC_IFETCH_STALL, SRC_DATA_STALL, SRC_ICACHE_STALL,
    SRC_DCACHE_STALL, SRC_CACHEABLE_STALL, SRC_XYRAM_STALL, SRC_URAM_STALL,
    SRC_MEM_ACC_STALL, SRC_OTHER_ACC_CYC, SRC_NC_ACC_CYC, SRC_NC_INST_CYC,
    SRC_NC_DATA_CYC, SRC_C_ACC_CYC, SRC_C_INST_CYC, SRC_C_DATA_CYC, SRC_OTHER_ACC_CNT,
    SRC_NC_ACC_CNT, SRC_NC_INST_CNT, SRC_NC_DATA_CNT, SRC_C_ACC_CNT, SRC_C_INST_CNT,
    SRC_C_DATA_CNT
  } src_sel_t;

  typedef enum logic [1:0] {
    MODE_NORMAL, MODE_RANGE_1_TO_2, MODE_RANGE_2_TO_1
  } meas_mode_t;

  // levels are cycle conditions, pulses are single events
  typedef struct packed {
    logic exec_state;
    logic branch;
    logic instr;
    logic dsp_instr;
    logic mem_conflict;
    logic other_conflict;
    logic exception;
    logic dtlb_miss;
    logic itlb_miss;
    logic interrupt;
    logic block_status_bit;
    logic privileged_mode_bit;
    logic icache_miss;
    logic dcache_miss;
    logic ifetch_stall;
    logic data_stall;
    logic icache_stall;
    logic dcache_stall;
    logic cacheable_stall;
    logic xyram_stall;
    logic uram_stall;
    logic inst_acc_cyc;
    logic data_acc_cyc;
    logic other_acc_cyc;
    logic inst_acc_start;
    logic data_acc_start;
    logic other_acc_start;
    logic area_cacheable;
  } cpu_events_t;

  typedef struct packed {
    logic break1_hit;
    logic break2_hit;
    logic other_break_hit;
    logic prog_start;
  } run_ctl_t;
endpackage
`default_nettype wire

//--- tb/perf_count_assertions.sv
/* checker on the counter's top ports
   assumes mclk is the only clock and rstn is async low */
`default_nettype none
module perf_count_assertions (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cpu_clk_run,
  input wire perf_count_pkg::run_ctl_t run_ctl,
  input wire logic sel_load,
  input wire logic init_req,
  input wire logic [3:0][31:0] count_value,
  input wire logic [3:0] overflow,
  input wire logic measuring,
  input wire logic step_allowed,
  input wire logic halt_request,
  input wire logic config_error
);
  timeunit 1ns;
  timeprecision 1ps;
  import perf_count_pkg::*;
  logic brk;
  // any break pulse this cycle
  assign brk = |run_ctl[3:1];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_halt_normal:
    assert property (halt_request == (step_allowed && brk)) else $error("halt wrong");
  a_range_error:
    assert property (config_error |-> !step_allowed) else $error("error in normal mode");
  a_init_clear:
    assert property (init_req |=> overflow == 4'h0) else $error("overflow kept");
  a_sleep_hold:
    assert property ((!measuring || !cpu_clk_run) && !init_req |=> $stable(count_value))
      else $error("count moved while idle");
  a_step_bound:
    assert property (measuring && !init_req |=>
      count_value[0] - $past(count_value[0]) <= 32'h0000_0002) else $error("step too big");
  a_normal_start:
    assert property (step_allowed && !measuring && run_ctl[0] && !brk && !sel_load
      |=> measuring) else $error("no start");
  a_normal_stop:
    assert property (step_allowed && measuring && brk |=> !measuring) else $error("no stop");
  a_ovf_sticky:
    assert property (!init_req |=> (overflow & $past(overflow)) == $past(overflow))
      else $error("overflow lost");
endmodule
bind perf_count perf_count_assertions chk (.mclk(mclk), .rstn(rstn),
  .cpu_clk_run(cpu_clk_run), .run_ctl(run_ctl), .sel_load(sel_load), .init_req(init_req),
  .count_value(count_value), .overflow(overflow), .measuring(measuring),
  .step_allowed(step_allowed), .halt_request(halt_request), .config_error(config_error));
`default_nettype wire

//--- tb/perf_host.sv
/* debugger-side model: loads channel setup and clears results
   assumes callers enter its tasks between edges of mclk */
`default_nettype none
module perf_host (
  input wire logic mclk,
  output var perf_count_pkg::src_sel_t sel [perf_count_pkg::NUM_CHAN],
  output var perf_count_pkg::meas_mode_t mode,
  output logic sel_load,
  output logic init_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import perf_count_pkg::*;
  // idle values before the first request
  initial begin
    sel = '{default: SRC_DISABLED};
    mode = MODE_NORMAL;
    sel_load = 1'b0;
    init_req = 1'b0;
  end
  // one load pulse with setup held across it
  task automatic load(input src_sel_t s0, s1, s2, s3, input meas_mode_t m);
    @(posedge mclk);
    sel <= '{s0, s1, s2, s3};
    mode <= m;
    sel_load <= 1'b1;
    @(posedge mclk);
    sel_load <= 1'b0;
  endtask
  // clear every count and flag
  task automatic clear();
    @(posedge mclk);
    init_req <= 1'b1;
    @(posedge mclk);
    init_req <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/perf_count_bench.sv
/* self-checking bench for the performance counter
   assumes the host model drives setup and clear pulses */
`default_nettype none
module perf_count_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import perf_count_pkg::*;
  logic mclk, rstn, cpu_run, sel_load, init_req, meas, step_ok, halt, cfg_err;
  cpu_events_t ev;
  run_ctl_t rc;
  src_sel_t sel [NUM_CHAN];
  meas_mode_t mode;
  logic [NUM_CHAN-1:0][CNT_W-1:0] cnt;
  logic [NUM_CHAN-1:0] ovf;
  logic [31:0] st;
  int failures = 0;
  int n_compared = 0;
  // status flags packed for one compare
  assign st = 32'({meas, step_ok, cfg_err, ovf});
  perf_host host (.mclk(mclk), .sel(sel), .mode(mode), .sel_load(sel_load),
    .init_req(init_req));
  perf_count uut (.mclk(mclk), .rstn(rstn), .cpu_clk_run(cpu_run), .cpu_ev(ev),
    .run_ctl(rc), .chan_sel_in(sel), .sel_load(sel_load), .mode_in(mode),
    .init_req(init_req), .count_value(cnt), .overflow(ovf), .measuring(meas),
    .step_allowed(step_ok), .halt_request(halt), .config_error(cfg_err));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one cpu cycle; f is {branch, instr, block bit, cacheable data access}
  task automatic cyc(input logic [3:0] r, input logic [3:0] f, input logic run);
    cpu_events_t e;
    e = '0;
    {e.branch, e.instr, e.block_status_bit, e.data_acc_start} = f;
    e.area_cacheable = f[0];
    @(posedge mclk);
    ev <= e;
    rc <= r;
    cpu_run <= run;
  endtask
  task automatic counts(input logic [31:0] a, b, c, d);
    #1;
    chk(cnt[0], a);
    chk(cnt[1], b);
    chk(cnt[2], c);
    chk(cnt[3], d);
  endtask
  // normal window with a sleep cycle inside
  task automatic normal_run();
    host.load(SRC_ELAPSED, SRC_BRANCH, SRC_INSTR, SRC_DISABLED, MODE_NORMAL);
    cyc(4'h1, 4'h0, 1'b1);
    cyc(4'h0, 4'h8, 1'b1);
    #1 chk(st, 32'h0000_0060);
    cyc(4'h0, 4'hc, 1'b0);
    cyc(4'h0, 4'h4, 1'b1);
    cyc(4'h8, 4'h0, 1'b1);
    #1 chk(32'(halt), 32'h0000_0001);
    cyc(4'h0, 4'h0, 1'b1);
    counts(32'h0000_0003, 32'h0000_0002, 32'h0000_0001, 32'h0000_0000);
    chk(st, 32'h0000_0020);
  endtask
  // range mode with no channel enabled never opens
  task automatic range_reject();
    host.load(SRC_DISABLED, SRC_DISABLED, SRC_DISABLED, SRC_DISABLED, MODE_RANGE_1_TO_2);
    #1 chk(st, 32'h0000_0010);
    cyc(4'h1, 4'h0, 1'b1);
    cyc(4'h8, 4'h0, 1'b1);
    cyc(4'h0, 4'h0, 1'b1);
    #1 chk(st, 32'h0000_0010);
  endtask
  // second break opens, first closes; armed cycles not counted
  task automatic range_run();
    host.load(SRC_ELAPSED, SRC_C_ACC_CNT, SRC_BLOCK_INSTR, SRC_PRIV_INSTR, MODE_RANGE_2_TO_1);
    #1 chk(st, 32'h0000_0000);
    cyc(4'h1, 4'h0, 1'b1);
    cyc(4'h0, 4'h6, 1'b1);
    cyc(4'h4, 4'h0, 1'b1);
    #1 chk(32'(halt), 32'h0000_0000);
    cyc(4'h0, 4'h1, 1'b1);
    #1 chk(st, 32'h0000_0040);
    cyc(4'h0, 4'h6, 1'b1);
    cyc(4'h8, 4'h4, 1'b1);
    cyc(4'h0, 4'h0, 1'b1);
    counts(32'h0000_0003, 32'h0000_0001, 32'h0000_0001, 32'h0000_0000);
    chk(st, 32'h0000_0000);
  endtask
  task automatic final_report();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard
  initial begin
    repeat (2000) @(posedge mclk);
    failures++;
    final_report();
  end
  // reset, then scenarios in order
  initial begin
    rstn = 1'b0;
    cpu_run = 1'b1;
    ev = '0;
    rc = '0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    counts(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    chk(st, 32'h0000_0020);
    normal_run();
    host.clear();
    counts(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    range_reject();
    range_run();
    final_report();
  end
endmodule
`default_nettype wire
